// ==== hdl/pdsf_top.sv ====
// Notes on behaviour
// - PLL output equals twice reference times loop divider plus one.
// - Reference is oscillator divided by reference divider plus one.
// - PLL output never drops below the self-clock minimum frequency.
// - With PLL selected, bus clock is PLL output divided by two.
// - Loop divider readable always; writes ignored while PLL selected.
// - Reference divider readable always; writes ignored while PLL selected.
// - Accepted divider write restarts lock and track detectors.
// - Factory test register reads zero; writes do nothing.
// - Timeout flag bit 7 sets per period, write-one clears, may interrupt.
// - Power-on flag bit 6 survives system reset, write-one clears.
// - Low-voltage flag bit 5 survives system reset; zero if feature absent.
// - Lock-change flag bit 4 sets on lock change, write-one clears.
// - Lock bit 3 read-only, forced zero in self-clock mode.
// - Track bit 2 read-only, forced zero in self-clock mode.
// - Self-clock change flag bit 1 sets on mode change, write-one clears.
// - Bit 0 shows self-clock operation.
// - Interrupt enable register holds enables at bits 7, 4 and 1.
// - Self-clock entered when monitor and self-clock enabled and clock lost.
`timescale 1ns/100ps
module pdsf_top #(
  parameter bit HAS_LVR = 1'b1
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_por_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire pdsf_pkg::pdsf_hw_t i_hw,
  output logic      [5:0]        o_loop_div,
  output logic      [3:0]        o_ref_div,
  output logic                   o_pll_sel,
  output logic                   o_detector_restart,
  output logic                   o_self_clock,
  output logic                   o_irq_req
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic       setup_req;
  logic       wr_req;
  logic [3:0] idx;
  logic       mapped;
  logic       lane0;
  assign setup_req = psel & ~penable;
  assign idx       = paddr[5:2];
  assign mapped    = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) && (idx <= 4'h6);
  assign lane0     = pstrb[0];
  // Writes commit in the access cycle, one wait-free answer
  assign wr_req    = psel & penable & pwrite & pready & mapped & lane0;

  logic [7:0] loop_div_reg;
  logic [7:0] ref_div_reg;
  logic [7:0] status_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] clk_sel_reg;
  logic [7:0] pll_ctl_reg;
  logic       por_reg;
  logic       lvr_reg;
  logic       lock_q_reg;
  logic       self_q_reg;
  logic       self_clk_reg;
  logic       div_wr;
  logic [7:0] clr_mask;

  assign div_wr   = wr_req && !clk_sel_reg[pdsf_pkg::BIT_PLL_SEL] &&
                    (idx == pdsf_pkg::IDX_LOOP_DIV || idx == pdsf_pkg::IDX_REF_DIV);
  assign clr_mask = (wr_req && idx == pdsf_pkg::IDX_STATUS) ? pwdata[7:0] : 8'h00;

  // ---------------------------------------------------------------
  // Handshake: ready one cycle after setup, error for unmapped
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_req;
      pslverr <= setup_req & ~mapped;
    end
  end

  // Read data captured at setup so it is stable in access
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup_req && !pwrite) begin
      case (idx)
        pdsf_pkg::IDX_LOOP_DIV:   prdata <= {24'h00_0000, loop_div_reg};
        pdsf_pkg::IDX_REF_DIV:    prdata <= {24'h00_0000, ref_div_reg};
        pdsf_pkg::IDX_TEST_FLAGS: prdata <= 32'h0000_0000;
        pdsf_pkg::IDX_STATUS:     prdata <= {24'h00_0000, status_reg};
        pdsf_pkg::IDX_IRQ_EN:     prdata <= {24'h00_0000, irq_en_reg};
        pdsf_pkg::IDX_CLK_SEL:    prdata <= {24'h00_0000, clk_sel_reg};
        pdsf_pkg::IDX_PLL_CTL:    prdata <= {24'h00_0000, pll_ctl_reg};
        default:                  prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Divider registers, locked while PLL clock selected
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      loop_div_reg <= pdsf_pkg::RST_LOOP_DIV;
      ref_div_reg  <= pdsf_pkg::RST_REF_DIV;
    end else if (div_wr) begin
      if (idx == pdsf_pkg::IDX_LOOP_DIV) begin
        loop_div_reg <= {2'b00, pwdata[pdsf_pkg::LOOP_DIV_W-1:0]};
      end else begin
        ref_div_reg  <= {4'h0, pwdata[pdsf_pkg::REF_DIV_W-1:0]};
      end
    end
  end

  // Divider settings to the analog loop; ratio is 2*(loop+1)/(ref+1)
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_loop_div         <= 6'h00;
      o_ref_div          <= 4'h0;
      o_detector_restart <= 1'b0;
    end else begin
      o_loop_div         <= loop_div_reg[5:0];
      o_ref_div          <= ref_div_reg[3:0];
      o_detector_restart <= div_wr;
    end
  end

  // ---------------------------------------------------------------
  // Clock select and PLL control (PLL control stores all eight written bits)
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_sel_reg <= 8'h00;
      pll_ctl_reg <= pdsf_pkg::RST_PLL_CTL;
    end else begin
      if (wr_req && idx == pdsf_pkg::IDX_PLL_CTL) begin
        pll_ctl_reg <= pwdata[7:0];
      end
      // Self-clock entry drops the PLL selection; unstable PLL not selectable
      if (self_clk_reg) begin
        clk_sel_reg[pdsf_pkg::BIT_PLL_SEL] <= 1'b0;
      end else if (wr_req && idx == pdsf_pkg::IDX_CLK_SEL) begin
        clk_sel_reg <= pwdata[7:0];
        if (!lock_q_reg) begin
          clk_sel_reg[pdsf_pkg::BIT_PLL_SEL] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Self-clock mode: enter on clock loss, leave on quality good
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      self_clk_reg <= 1'b0;
    end else if (pll_ctl_reg[pdsf_pkg::BIT_CLK_MON] && pll_ctl_reg[pdsf_pkg::BIT_SELF_EN]
                 && i_hw.osc_lost) begin
      self_clk_reg <= 1'b1;
    end else if (i_hw.osc_good) begin
      self_clk_reg <= 1'b0;
    end
  end

  // Live lock state, forced low in self-clock and on restart
  logic lock_now;
  logic track_now;
  assign lock_now  = i_hw.pll_lock  & ~self_clk_reg & ~div_wr;
  assign track_now = i_hw.pll_track & ~self_clk_reg & ~div_wr;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_q_reg <= 1'b0;
      self_q_reg <= 1'b0;
    end else begin
      lock_q_reg <= lock_now;
      self_q_reg <= self_clk_reg;
    end
  end

  // ---------------------------------------------------------------
  // Reset-source flags: reset only by power-on reset, cleared by write one
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_por_n) begin
    if (!i_por_n) begin
      por_reg <= 1'b1;
      lvr_reg <= 1'b0;
    end else begin
      if (i_hw.por_evt) begin
        por_reg <= 1'b1;
      end else if (clr_mask[pdsf_pkg::BIT_POR]) begin
        por_reg <= 1'b0;
      end
      if (i_hw.lvr_evt && HAS_LVR) begin
        lvr_reg <= 1'b1;
      end else if (clr_mask[pdsf_pkg::BIT_LVR]) begin
        lvr_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sticky event flags, set beats clear
  // ---------------------------------------------------------------
  logic tmo_reg;
  logic lck_chg_reg;
  logic scm_chg_reg;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmo_reg     <= 1'b0;
      lck_chg_reg <= 1'b0;
      scm_chg_reg <= 1'b0;
    end else begin
      tmo_reg     <= i_hw.timeout_evt | (tmo_reg & ~clr_mask[pdsf_pkg::BIT_TIMEOUT]);
      lck_chg_reg <= (lock_now ^ lock_q_reg) |
                     (lck_chg_reg & ~clr_mask[pdsf_pkg::BIT_LOCK_CHG]);
      scm_chg_reg <= (self_clk_reg ^ self_q_reg) |
                     (scm_chg_reg & ~clr_mask[pdsf_pkg::BIT_SELF_CHG]);
    end
  end

  // Status image as read by software; the lock bit lags one cycle, so it is
  // masked again here to stay low in the first self-clock cycle
  assign status_reg = {tmo_reg, por_reg, lvr_reg & HAS_LVR, lck_chg_reg,
                       lock_q_reg & ~self_clk_reg, track_now, scm_chg_reg,
                       self_clk_reg};

  // Interrupt enables, only implemented bits stored
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en_reg <= pdsf_pkg::RST_IRQ_EN;
    end else if (wr_req && idx == pdsf_pkg::IDX_IRQ_EN) begin
      irq_en_reg <= pwdata[7:0] & pdsf_pkg::IRQ_EN_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Outputs from flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_req    <= 1'b0;
      o_pll_sel    <= 1'b0;
      o_self_clock <= 1'b0;
    end else begin
      o_irq_req    <= |(status_reg & irq_en_reg & pdsf_pkg::IRQ_EN_MASK);
      o_pll_sel    <= clk_sel_reg[pdsf_pkg::BIT_PLL_SEL];
      o_self_clock <= self_clk_reg;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  lock_div_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    clk_sel_reg[7] |-> ##1 $stable(loop_div_reg) && $stable(ref_div_reg))
    else $error("divider changed while PLL selected");
  ref_lock_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_req && idx == 4'h1 && clk_sel_reg[7]) |=> $stable(ref_div_reg))
    else $error("reference divider written while PLL selected");
  restart_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    div_wr |=> o_detector_restart)
    else $error("detector restart missing");
  test_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (setup_req && !pwrite && idx == 4'h2) |=> prdata == 32'h0)
    else $error("test register not zero");
  tmo_keep_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_hw.timeout_evt |=> tmo_reg)
    else $error("timeout flag lost");
  tmo_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (tmo_reg && !clr_mask[7] && !i_hw.timeout_evt) |=> tmo_reg)
    else $error("timeout flag cleared without write one");
  lock_chg_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (lock_now != lock_q_reg) |=> lck_chg_reg)
    else $error("lock change not flagged");
  self_force_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    self_clk_reg |-> !status_reg[3] && !status_reg[2])
    else $error("lock or track shown in self-clock");
  self_chg_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $changed(self_clk_reg) |=> scm_chg_reg ##1 o_self_clock == $past(self_clk_reg, 2))
    else $error("self-clock change not flagged");
  irq_out_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (tmo_reg && irq_en_reg[7]) |=> o_irq_req)
    else $error("interrupt request missing");
  self_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (pll_ctl_reg[7] && pll_ctl_reg[0] && i_hw.osc_lost) |=> self_clk_reg)
    else $error("self-clock not entered");

endmodule : pdsf_top

// ==== pkg/pdsf_pkg.sv ====
package pdsf_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_LOOP_DIV   = 4'h0;
  localparam logic [3:0] IDX_REF_DIV    = 4'h1;
  localparam logic [3:0] IDX_TEST_FLAGS = 4'h2;
  localparam logic [3:0] IDX_STATUS     = 4'h3;
  localparam logic [3:0] IDX_IRQ_EN     = 4'h4;
  localparam logic [3:0] IDX_CLK_SEL    = 4'h5;
  localparam logic [3:0] IDX_PLL_CTL    = 4'h6;

  // ---------------------------------------------------------------
  // Field widths and positions
  // ---------------------------------------------------------------
  localparam int LOOP_DIV_W = 6;
  localparam int REF_DIV_W  = 4;
  localparam int BIT_TIMEOUT   = 7;
  localparam int BIT_POR       = 6;
  localparam int BIT_LVR       = 5;
  localparam int BIT_LOCK_CHG  = 4;
  localparam int BIT_LOCK      = 3;
  localparam int BIT_TRACK     = 2;
  localparam int BIT_SELF_CHG  = 1;
  localparam int BIT_SELF_CLK  = 0;
  localparam int BIT_PLL_SEL   = 7;
  localparam int BIT_CLK_MON   = 7;
  localparam int BIT_SELF_EN   = 0;

  // ---------------------------------------------------------------
  // Reset values and interrupt enable mask
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_LOOP_DIV = 8'h00;
  localparam logic [7:0] RST_REF_DIV  = 8'h00;
  localparam logic [7:0] RST_IRQ_EN   = 8'h00;
  localparam logic [7:0] RST_PLL_CTL  = 8'h81;
  localparam logic [7:0] IRQ_EN_MASK  = 8'h92;

  // Clock rate of the bus clock
  localparam int MCLK_MHZ = 100;

  // Hardware status inputs grouped together
  typedef struct packed {
    logic timeout_evt;
    logic por_evt;
    logic lvr_evt;
    logic pll_lock;
    logic pll_track;
    logic osc_lost;
    logic osc_good;
  } pdsf_hw_t;

endpackage : pdsf_pkg

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic               i_mclk, i_rst_n, i_por_n, psel, penable, pwrite;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rv;
  logic [3:0]         pstrb, o_ref_div;
  logic [5:0]         o_loop_div;
  logic               pready, pslverr, ev;
  logic               o_pll_sel, o_detector_restart, o_self_clock, o_irq_req;
  pdsf_pkg::pdsf_hw_t hw;
  int                 fails, n_checks, cycles, restarts, n;

  pdsf_top dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_por_n(i_por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_hw(hw),
    .o_loop_div(o_loop_div), .o_ref_div(o_ref_div), .o_pll_sel(o_pll_sel),
    .o_detector_restart(o_detector_restart), .o_self_clock(o_self_clock),
    .o_irq_req(o_irq_req));

  // Clock source
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // Cycle limit and detector restart pulse counter
  always @(posedge i_mclk) begin
    cycles++;
    if (o_detector_restart === 1'b1) restarts++;
    if (cycles >= 20000) begin
      fails++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; evt raises a timeout event during the access cycle
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] d, input bit evt);
    int t;
    t = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {6'h00, idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge i_mclk);
    penable <= 1'b1;
    if (evt) hw.timeout_evt <= 1'b1;
    do begin
      @(posedge i_mclk);
      t++;
    end while (pready !== 1'b1 && t < 40);
    if (t >= 40) begin
      fails++;
      end_sim();
    end
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (evt) hw.timeout_evt <= 1'b0;
    @(posedge i_mclk);
  endtask : apb

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [3:0] idx);
    apb(1'b0, idx, 8'h00, 1'b0);
  endtask : rd

  task automatic idle(input int k);
    repeat (k) @(posedge i_mclk);
  endtask : idle

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(pdsf_pkg::IDX_LOOP_DIV); chk("loop_div", rv, 32'h00000000);
    rd(pdsf_pkg::IDX_REF_DIV);  chk("ref_div", rv, 32'h00000000);
    rd(pdsf_pkg::IDX_IRQ_EN);   chk("irq_en", rv, 32'h00000000);
    rd(pdsf_pkg::IDX_PLL_CTL);  chk("pll_ctl", rv, 32'h00000081);
    rd(pdsf_pkg::IDX_STATUS);   chk("status", rv, 32'h00000040);
    $display("test reset done");
  endtask : t_reset

  task automatic t_div;
    n = restarts;
    wr(pdsf_pkg::IDX_LOOP_DIV, 8'hff);
    rd(pdsf_pkg::IDX_LOOP_DIV); chk("loop_div", rv, 32'h0000003f);
    chk("o_loop_div", {26'h0, o_loop_div}, 32'h0000003f);
    wr(pdsf_pkg::IDX_REF_DIV, 8'hff);
    rd(pdsf_pkg::IDX_REF_DIV);  chk("ref_div", rv, 32'h0000000f);
    chk("o_ref_div", {28'h0, o_ref_div}, 32'h0000000f);
    chk("restarts", restarts - n, 2);
    wr(pdsf_pkg::IDX_TEST_FLAGS, 8'hff);
    rd(pdsf_pkg::IDX_TEST_FLAGS); chk("test_flags", rv, 32'h00000000);
    wr(4'h7, 8'h01); chk("unmapped_err", {31'h0, ev}, 32'h1);
    $display("test dividers done");
  endtask : t_div

  task automatic t_flags;
    wr(pdsf_pkg::IDX_IRQ_EN, 8'hff);
    rd(pdsf_pkg::IDX_IRQ_EN); chk("irq_en", rv, 32'h00000092);
    hw.timeout_evt <= 1'b1; idle(1); hw.timeout_evt <= 1'b0; idle(2);
    rd(pdsf_pkg::IDX_STATUS); chk("timeout", {31'h0, rv[7]}, 32'h1);
    chk("irq", {31'h0, o_irq_req}, 32'h1);
    wr(pdsf_pkg::IDX_STATUS, 8'h00);
    rd(pdsf_pkg::IDX_STATUS); chk("timeout_w0", {31'h0, rv[7]}, 32'h1);
    apb(1'b1, pdsf_pkg::IDX_STATUS, 8'h80, 1'b1);
    rd(pdsf_pkg::IDX_STATUS); chk("set_wins", {31'h0, rv[7]}, 32'h1);
    wr(pdsf_pkg::IDX_STATUS, 8'h80); idle(2);
    rd(pdsf_pkg::IDX_STATUS); chk("timeout_w1", {31'h0, rv[7]}, 32'h0);
    chk("irq_off", {31'h0, o_irq_req}, 32'h0);
    hw.lvr_evt <= 1'b1; idle(1); hw.lvr_evt <= 1'b0; idle(2);
    i_rst_n <= 1'b0; idle(2); i_rst_n <= 1'b1; idle(1);
    rd(pdsf_pkg::IDX_STATUS); chk("por_lvr", rv & 32'h60, 32'h60);
    wr(pdsf_pkg::IDX_STATUS, 8'h60);
    rd(pdsf_pkg::IDX_STATUS); chk("por_lvr_clr", rv & 32'h60, 32'h00);
    $display("test flags done");
  endtask : t_flags

  task automatic t_lock;
    wr(pdsf_pkg::IDX_IRQ_EN, 8'h10);
    hw.pll_lock <= 1'b1; hw.pll_track <= 1'b1; idle(3);
    rd(pdsf_pkg::IDX_STATUS); chk("lock_bits", rv & 32'h1c, 32'h1c);
    chk("lock_irq", {31'h0, o_irq_req}, 32'h1);
    wr(pdsf_pkg::IDX_STATUS, 8'h10);
    rd(pdsf_pkg::IDX_STATUS); chk("lock_chg_clr", rv & 32'h10, 32'h0);
    // Select output settles one edge after the write lands
    wr(pdsf_pkg::IDX_CLK_SEL, 8'h80); idle(1);
    chk("pll_sel", {31'h0, o_pll_sel}, 32'h1);
    n = restarts;
    wr(pdsf_pkg::IDX_LOOP_DIV, 8'h05); wr(pdsf_pkg::IDX_REF_DIV, 8'h03);
    // Dividers hold their values from the system reset in the flags test
    rd(pdsf_pkg::IDX_LOOP_DIV); chk("loop_locked", rv, {24'h0, pdsf_pkg::RST_LOOP_DIV});
    rd(pdsf_pkg::IDX_REF_DIV);  chk("ref_locked", rv, {24'h0, pdsf_pkg::RST_REF_DIV});
    chk("no_restart", restarts - n, 0);
    $display("test lock done");
  endtask : t_lock

  task automatic t_self;
    wr(pdsf_pkg::IDX_IRQ_EN, 8'h02);
    hw.osc_lost <= 1'b1; idle(3);
    rd(pdsf_pkg::IDX_STATUS); chk("self_bits", rv & 32'h0f, 32'h03);
    chk("self_clk", {31'h0, o_self_clock}, 32'h1);
    chk("sel_drop", {31'h0, o_pll_sel}, 32'h0);
    chk("self_irq", {31'h0, o_irq_req}, 32'h1);
    hw.osc_lost <= 1'b0; hw.osc_good <= 1'b1; idle(3);
    chk("self_exit", {31'h0, o_self_clock}, 32'h0);
    hw.osc_good <= 1'b0;
    wr(pdsf_pkg::IDX_PLL_CTL, 8'h00);
    hw.osc_lost <= 1'b1; idle(3);
    chk("no_self", {31'h0, o_self_clock}, 32'h0);
    hw.osc_lost <= 1'b0;
    $display("test self clock done");
  endtask : t_self

  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb   = 4'hf;
    hw      = '0;
    i_rst_n = 1'b0;
    i_por_n = 1'b0;
    idle(8);
    i_rst_n <= 1'b1;
    i_por_n <= 1'b1;
    idle(1);
    t_reset();
    t_div();
    t_flags();
    t_lock();
    t_self();
    end_sim();
  end
endmodule : testbench
